/* File: pthf_pkg.sv */
// Purpose: Constants for the task header framer.
// Assumes: 16-byte headers, high byte first.
// Notes: Register offsets are byte addresses.
package pthf_pkg;
   localparam int HDR_LEN = 16;
   localparam logic [7:0] SYS_ID_0 = 8'h53;
   localparam logic [7:0] SYS_ID_1 = 8'h35;
   localparam logic [7:0] HDR_LEN_B = 8'h10;
   localparam logic [7:0] OP_IDENT = 8'h01;
   localparam logic [7:0] OP_LEN = 8'h03;
   localparam logic [7:0] OP_WRITE_REQ = 8'h03;
   localparam logic [7:0] OP_WRITE_ACK = 8'h04;
   localparam logic [7:0] OP_READ_REQ = 8'h05;
   localparam logic [7:0] OP_READ_ACK = 8'h06;
   localparam logic [7:0] OP_TRANSP = 8'h07;
   localparam logic [7:0] ORG_BLK = 8'h03;
   localparam logic [7:0] ORG_BLK_LEN = 8'h08;
   localparam logic [7:0] UNUSED_BLK = 8'hff;
   localparam logic [7:0] UNUSED_LEN_REQ = 8'h02;
   localparam logic [7:0] ACK_BLK = 8'h0f;
   localparam logic [7:0] ACK_BLK_LEN = 8'h03;
   localparam logic [7:0] UNUSED_LEN_ACK = 8'h07;
   localparam logic [15:0] LEN_FORBIDDEN = 16'hffff;
   localparam logic [15:0] JOKER_LEN = 16'hffff;
   localparam logic [3:0] BLK_SIZE_WORDS = 4'h6;
   // Error reason codes
   localparam logic [3:0] ERR_NONE = 4'h0;
   localparam logic [3:0] ERR_NO_CONN = 4'ha;
   localparam logic [3:0] ERR_NO_TASK = 4'hf;
   // Indicator word bit positions
   localparam int IND_HS_OK = 0;
   localparam int IND_ACTIVE = 1;
   localparam int IND_DONE_OK = 2;
   localparam int IND_DONE_ERR = 3;
   localparam int IND_ERR_LSB = 8;
   // Register byte offsets
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_TXORG = 8'h04;
   localparam logic [7:0] REG_TXADDR = 8'h08;
   localparam logic [7:0] REG_STATUS = 8'h0c;
   localparam logic [7:0] REG_RXORG = 8'h10;
   localparam logic [7:0] REG_RXADDR = 8'h14;
   localparam logic [7:0] REG_XFER = 8'h18;
   localparam logic [7:0] REG_INDIC = 8'h1c;
   // Control register fields
   localparam int CTRL_GO = 0;
   localparam int CTRL_OP_LSB = 8;
   localparam int CTRL_ERRNO_LSB = 16;
   localparam int CTRL_CONNECTION_PRIORITY_LSB = 24;
   localparam int CTRL_MSG = 26;
   localparam int CTRL_CFG = 27;
   localparam int CTRL_CONN = 28;
   localparam int CTRL_BLK_LSB = 4;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_DECERR = 2'b11;
endpackage : pthf_pkg

/* File: pthf_rx_parser.sv */
// Purpose: Parses one incoming 16-byte header from the byte stream.
// Assumes: Bytes arrive high byte first on the same clock.
// Notes: Done pulses with byte 15 itself; fields are stable then.
`timescale 1ns/1ps
`default_nettype none
module pthf_rx_parser import pthf_pkg::*; (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic byteValid,
   input wire logic [7:0] byteData,
   output logic hdrDone,
   output logic hdrBad,
   output logic [7:0] opcode,
   output logic [7:0] field8,
   output logic [7:0] field9,
   output logic [15:0] field10,
   output logic [15:0] field12
);
   logic [3:0] idx;
   logic bad;
   logic [7:0] expect_b;
   logic check;

   // Fixed byte expected at each of positions 0 to 4; later positions are not checked
   always_comb begin
      expect_b = 8'h00;
      check = 1'b1;
      unique case (idx)
         4'd0: expect_b = SYS_ID_0;
         4'd1: expect_b = SYS_ID_1;
         4'd2: expect_b = HDR_LEN_B;
         4'd3: expect_b = OP_IDENT;
         4'd4: expect_b = OP_LEN;
         default: check = 1'b0;
      endcase
   end

   // Done with the last byte, so the very next byte may be payload
   assign hdrDone = byteValid && idx == 4'd15;
   assign hdrBad = bad;

   // Byte position and field capture
   always_ff @(posedge core_clk) begin
      if (rst) begin
         idx <= 4'd0;
         bad <= 1'b0;
         opcode <= 8'h00;
         field8 <= 8'h00;
         field9 <= 8'h00;
         field10 <= 16'h0000;
         field12 <= 16'h0000;
      end else if (byteValid) begin
         idx <= idx + 4'd1;
         if (idx == 4'd0) bad <= (check && byteData != expect_b);
         else if (check && byteData != expect_b) bad <= 1'b1;
         unique case (idx)
            4'd5: opcode <= byteData;
            4'd8: field8 <= byteData;
            4'd9: field9 <= byteData;
            4'd10: field10[15:8] <= byteData;
            4'd11: field10[7:0] <= byteData;
            4'd12: field12[15:8] <= byteData;
            4'd13: field12[7:0] <= byteData;
            default: ;
         endcase
      end
   end
endmodule : pthf_rx_parser
`default_nettype wire

/* File: pthf_framer.sv */
// Purpose: Task header framer with indicator word, reached over AXI4-Lite.
// Assumes: Single clock, synchronous reset, byte streams on the same clock.
// Notes: Builds request/ack/transparent headers and parses incoming ones.
//
// What this block does
// - Requests: S,5, length 16, ident 01/03, ORG 03/08, unused FF/02.
// - Opcode 03 write, 05 read request; receiver decodes it.
// - ORG block: id, block number, start, length; length never FFFF.
// - Acks: opcode 04/06, ack block 0F/03 with error, unused FF/07.
// - Transparent mode: 16-byte length header before user data.
// - Transparent header opcode 07; block number ignored.
// - Transparent length field delimits received payload.
// - Receive length -1 adopts incoming header length.
// - Joker length reports header length as transfer length.
// - Block size code 6: length counts words.
// - Indicator bit 0: message or receive initiation possible.
// - Bit 1 set on task start, cleared on completion.
// - Bit 2 set on error-free completion, cleared on restart.
// - Bit 3 set on completion with error, cleared on restart.
// - While bit 3 set, high byte holds error reason.
// - Error code in second byte bits 0-3; 0 is none.
// - Code F: task unconfigured; code A: no connection.
//
// The AXI4-Lite interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module pthf_framer import pthf_pkg::*; #(
   parameter int ADDR_W = 8
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic txValid,
   output logic [7:0] txData,
   output logic txLast,
   input wire logic txReady,
   input wire logic rxValid,
   input wire logic [7:0] rxData
);
   typedef enum logic [2:0] {
      PTHF_IDLE = 3'b001,
      PTHF_SEND = 3'b010,
      PTHF_WAIT = 3'b100
   } pthf_state_t;

   pthf_state_t state;
   logic [31:0] ctrl, txOrg, txAddr, rxLenParam;
   logic [15:0] indic, xferLen;
   logic [31:0] rxOrgReg, rxAddrReg;
   logic [3:0] txIdx;
   logic [7:0] next_txByte;
   logic awHeld, wHeld;
   logic [ADDR_W-1:0] awAddr;
   logic [31:0] wData;
   logic [3:0] wStrb;
   logic hdrDone, hdrBad;
   logic [7:0] rxOp, rxF8, rxF9;
   logic [15:0] rxF10, rxF12;
   logic [15:0] rxPayLeft;
   logic rxBusy;
   logic [7:0] opSel;
   logic isAck, ackOk, lenBad, goPulse;

   // Incoming header parser; bytes past a transparent or write request header go to payload counting
   pthf_rx_parser u_parser (
      .core_clk(core_clk),
      .rst(rst),
      .byteValid(rxValid && !rxBusy),
      .byteData(rxData),
      .hdrDone(hdrDone),
      .hdrBad(hdrBad),
      .opcode(rxOp),
      .field8(rxF8),
      .field9(rxF9),
      .field10(rxF10),
      .field12(rxF12)
   );

   assign opSel = ctrl[CTRL_OP_LSB +: 8];
   assign isAck = (opSel == OP_WRITE_ACK) || (opSel == OP_READ_ACK);
   assign ackOk = (ctrl[CTRL_ERRNO_LSB +: 8] == 8'h00);
   assign lenBad = (txAddr[15:0] == LEN_FORBIDDEN);
   assign goPulse = ctrl[CTRL_GO]; // Self-clearing go, seen once ctrl has landed

   // AXI write channel: take address and data in either order
   always_ff @(posedge core_clk) begin
      if (rst) begin
         awHeld <= 1'b0;
         wHeld <= 1'b0;
         awAddr <= '0;
         wData <= 32'h0;
         wStrb <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            awHeld <= 1'b1;
            awAddr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wHeld <= 1'b1;
            wData <= s_axi_wdata;
            wStrb <= s_axi_wstrb;
         end
         if (awHeld && wHeld && !s_axi_bvalid) begin
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (awAddr <= REG_RXADDR && awAddr[1:0] == 2'b00 &&
               awAddr != REG_STATUS && awAddr != REG_RXORG) ? RESP_OKAY : RESP_DECERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Ready only while nothing of that channel is held
   always_ff @(posedge core_clk) begin
      if (rst) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
      end else begin
         s_axi_awready <= !awHeld && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
         s_axi_wready <= !wHeld && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
      end
   end

   // Software registers with byte enables
   always_ff @(posedge core_clk) begin
      if (rst) begin
         ctrl <= 32'h0;
         txOrg <= 32'h0;
         txAddr <= 32'h0;
         rxLenParam <= 32'h0;
      end else begin
         ctrl[CTRL_GO] <= 1'b0;
         if (awHeld && wHeld && !s_axi_bvalid) begin
            for (int b = 0; b < 4; b++) begin
               if (wStrb[b]) begin
                  unique case (awAddr)
                     REG_CTRL: ctrl[b*8 +: 8] <= wData[b*8 +: 8];
                     REG_TXORG: txOrg[b*8 +: 8] <= wData[b*8 +: 8];
                     REG_TXADDR: txAddr[b*8 +: 8] <= wData[b*8 +: 8];
                     REG_RXADDR: rxLenParam[b*8 +: 8] <= wData[b*8 +: 8];
                     default: ;
                  endcase
               end
            end
         end
      end
   end

   // AXI read channel
   always_ff @(posedge core_clk) begin
      if (rst) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= RESP_OKAY;
      end else begin
         s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= RESP_OKAY;
            unique case (s_axi_araddr)
               REG_CTRL: s_axi_rdata <= ctrl;
               REG_TXORG: s_axi_rdata <= txOrg;
               REG_TXADDR: s_axi_rdata <= txAddr;
               REG_STATUS: s_axi_rdata <= {29'h0, hdrBad, lenBad, state != PTHF_IDLE};
               REG_RXORG: s_axi_rdata <= rxOrgReg;
               REG_RXADDR: s_axi_rdata <= rxAddrReg;
               REG_XFER: s_axi_rdata <= {16'h0, xferLen};
               REG_INDIC: s_axi_rdata <= {16'h0, indic};
               default: begin
                  s_axi_rdata <= 32'h0;
                  s_axi_rresp <= RESP_DECERR;
               end
            endcase
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // Header byte generator by position
   always_comb begin
      next_txByte = 8'h00;
      unique case (txIdx)
         4'd0: next_txByte = SYS_ID_0;
         4'd1: next_txByte = SYS_ID_1;
         4'd2: next_txByte = HDR_LEN_B;
         4'd3: next_txByte = OP_IDENT;
         4'd4: next_txByte = OP_LEN;
         4'd5: next_txByte = opSel;
         4'd6: next_txByte = isAck ? ACK_BLK : ORG_BLK;
         4'd7: next_txByte = isAck ? ACK_BLK_LEN : ORG_BLK_LEN;
         4'd8: next_txByte = isAck ? ctrl[CTRL_ERRNO_LSB +: 8] : txOrg[7:0];
         4'd9: next_txByte = isAck ? UNUSED_BLK : txOrg[15:8];
         4'd10: next_txByte = isAck ? UNUSED_LEN_ACK : txAddr[31:24];
         4'd11: next_txByte = isAck ? 8'h00 : txAddr[23:16];
         4'd12: next_txByte = isAck ? 8'h00 : txAddr[15:8];
         4'd13: next_txByte = isAck ? 8'h00 : txAddr[7:0];
         4'd14: next_txByte = isAck ? 8'h00 : UNUSED_BLK;
         4'd15: next_txByte = isAck ? 8'h00 : UNUSED_LEN_REQ;
         default: ;
      endcase
   end

   // Transmit sequencer; payload after read ack only when error is zero
   always_ff @(posedge core_clk) begin
      if (rst) begin
         state <= PTHF_IDLE;
         txIdx <= 4'd0;
         txValid <= 1'b0;
         txData <= 8'h00;
         txLast <= 1'b0;
      end else begin
         unique case (state)
            PTHF_IDLE: if (goPulse && !indic[IND_ACTIVE] && !(lenBad && !isAck)) begin
               state <= PTHF_SEND;
               txIdx <= 4'd0;
            end
            PTHF_SEND: begin
               if (!txValid || txReady) begin
                  txValid <= 1'b1;
                  txData <= next_txByte;
                  txLast <= (txIdx == 4'd15) && !(isAck && ackOk && opSel == OP_READ_ACK);
                  txIdx <= txIdx + 4'd1;
                  if (txIdx == 4'd15) state <= PTHF_WAIT;
               end
            end
            PTHF_WAIT: if (txReady) begin
               txValid <= 1'b0;
               txLast <= 1'b0;
               state <= PTHF_IDLE;
            end
            default: state <= PTHF_IDLE;
         endcase
      end
   end

   // Receive result capture and payload delimiting
   always_ff @(posedge core_clk) begin
      if (rst) begin
         rxOrgReg <= 32'h0;
         rxAddrReg <= 32'h0;
         rxBusy <= 1'b0;
         rxPayLeft <= 16'h0;
         xferLen <= 16'h0;
      end else begin
         if (hdrDone && !hdrBad) begin
            rxOrgReg <= {8'h00, (rxOp == OP_TRANSP) ? 8'h00 : rxF9, rxF8, rxOp};
            rxAddrReg <= {rxF10, rxF12};
            if (rxOp == OP_TRANSP || rxOp == OP_WRITE_REQ) begin
               rxPayLeft <= (ctrl[CTRL_BLK_LSB +: 4] == BLK_SIZE_WORDS) ?
                  {rxF12[14:0], 1'b0} : rxF12;
               rxBusy <= (rxF12 != 16'h0);
               xferLen <= (rxLenParam[15:0] == JOKER_LEN) ? rxF12 : rxLenParam[15:0];
            end
         end else if (rxBusy && rxValid) begin
            rxPayLeft <= rxPayLeft - 16'd1;
            if (rxPayLeft == 16'd1) rxBusy <= 1'b0;
         end
      end
   end

   // Indicator word status nibble and error code
   always_ff @(posedge core_clk) begin
      if (rst) begin
         indic <= 16'h0;
      end else begin
         indic[IND_HS_OK] <= (ctrl[CTRL_CONNECTION_PRIORITY_LSB +: 2] == 2'd1) ? ctrl[CTRL_MSG] :
            (ctrl[CTRL_CONNECTION_PRIORITY_LSB +: 2] != 2'd0) && ctrl[CTRL_CONN];
         if (goPulse && !indic[IND_ACTIVE] && !(lenBad && !isAck)) begin
            if (!ctrl[CTRL_CFG] || !ctrl[CTRL_CONN]) begin
               indic[IND_DONE_ERR] <= 1'b1;
               indic[IND_DONE_OK] <= 1'b0;
               indic[IND_ERR_LSB +: 4] <= !ctrl[CTRL_CFG] ? ERR_NO_TASK : ERR_NO_CONN;
            end else begin
               indic[IND_ACTIVE] <= 1'b1;
               indic[IND_DONE_OK] <= 1'b0;
               indic[IND_DONE_ERR] <= 1'b0;
               indic[IND_ERR_LSB +: 4] <= ERR_NONE;
            end
         end else if (indic[IND_ACTIVE] && hdrDone && !hdrBad &&
               (rxOp == OP_WRITE_ACK || rxOp == OP_READ_ACK)) begin
            indic[IND_ACTIVE] <= 1'b0;
            indic[IND_DONE_OK] <= (rxF8 == 8'h00);
            indic[IND_DONE_ERR] <= (rxF8 != 8'h00);
            indic[IND_ERR_LSB +: 4] <= rxF8[3:0];
         end
      end
   end
endmodule : pthf_framer
`default_nettype wire

/* File: pthf_framer_properties.sv */
// Purpose: Port checker for the framer.
// Assumes: One clock, sync reset.
// Notes: Counts outgoing bytes to judge bytes 0-7 of every header and 13-15 of requests.
`timescale 1ns/1ps
`default_nettype none
module pthf_framer_checker import pthf_pkg::*; #(
   parameter int ADDR_W = 8
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_rvalid,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic txValid,
   input wire logic [7:0] txData,
   input wire logic txLast,
   input wire logic txReady
);
   logic [3:0] txIdx;
   logic [7:0] txOp;
   logic [7:0] lenHi;
   logic [ADDR_W-1:0] rdAddr;
   logic isAck;
   logic indRd;
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   // Byte index within the outgoing header
   always_ff @(posedge core_clk) begin
      if (rst) txIdx <= 4'h0;
      else if (txValid && txReady) txIdx <= txIdx + 4'h1;
   end
   // Remembered opcode, length high byte and read address
   always_ff @(posedge core_clk) begin
      if (txValid && txReady && txIdx == 4'h5) txOp <= txData;
      if (txValid && txReady && txIdx == 4'hc) lenHi <= txData;
      if (s_axi_arvalid && s_axi_arready) rdAddr <= s_axi_araddr;
   end
   // Header kind and indicator read decode
   assign isAck = (txOp == OP_WRITE_ACK) || (txOp == OP_READ_ACK);
   assign indRd = s_axi_rvalid && rdAddr == ADDR_W'(REG_INDIC) && s_axi_rresp == RESP_OKAY;
   AST_TX_ID: assert property (txValid && txIdx < 4'h2 |->
      txData == (txIdx[0] ? SYS_ID_1 : SYS_ID_0)) else $error("bad id");
   AST_TX_HLEN: assert property (txValid && txIdx inside {[4'h2:4'h4]} |->
      txData == (txIdx == 4'h2 ? HDR_LEN_B : (txIdx == 4'h3 ? OP_IDENT : OP_LEN)))
      else $error("bad fixed byte");
   AST_TX_OPCODE: assert property (txValid && txIdx == 4'h5 |->
      txData inside {[OP_WRITE_REQ:OP_TRANSP]}) else $error("bad opcode");
   AST_TX_BLOCK: assert property (txValid && txIdx inside {4'h6, 4'h7} |-> txData ==
      (isAck ? (txIdx[0] ? ACK_BLK_LEN : ACK_BLK) : (txIdx[0] ? ORG_BLK_LEN : ORG_BLK)))
      else $error("bad block");
   AST_TX_TAIL: assert property (txValid && !isAck && txIdx >= 4'he |->
      txData == (txIdx[0] ? UNUSED_LEN_REQ : UNUSED_BLK)) else $error("bad tail");
   AST_TX_LENOK: assert property (txValid && !isAck && txIdx == 4'hd |->
      !(lenHi == 8'hff && txData == 8'hff)) else $error("length FFFF");
   AST_TX_HOLD: assert property (txValid && !txReady |=>
      txValid && $stable(txData) && $stable(txLast)) else $error("byte not held");
   AST_TX_LAST: assert property (txValid && txLast |-> txIdx == 4'hf)
      else $error("stray last");
   AST_IND_EXCL: assert property (indRd |->
      !(s_axi_rdata[IND_DONE_OK] && s_axi_rdata[IND_DONE_ERR])) else $error("both done bits");
   AST_IND_CODE: assert property (indRd && s_axi_rdata[IND_DONE_ERR] |->
      s_axi_rdata[IND_ERR_LSB +: 4] != ERR_NONE) else $error("no error code");
   COV_WACK: cover property (txValid && txReady && txIdx == 4'h5 && txData == OP_WRITE_ACK);
   COV_TRANSP: cover property (txValid && txReady && txIdx == 4'h5 && txData == OP_TRANSP);
   COV_ERR: cover property (indRd && s_axi_rdata[IND_DONE_ERR]);
endmodule : pthf_framer_checker
bind pthf_framer pthf_framer_checker #(.ADDR_W(ADDR_W)) pthf_framer_checker_i (.core_clk, .rst,
   .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rdata, .s_axi_rresp,
   .txValid, .txData, .txLast, .txReady);
`default_nettype wire

/* File: pthf_remote_station.sv */
// Purpose: Remote station model: sinks tx bytes, sources rx frames.
// Assumes: Same clock as the framer; one frame at a time.
// Notes: Idle rx data flips every cycle so stale bytes never look valid.
`timescale 1ns/1ps
`default_nettype none
module pthf_remote_station (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic stall,
   input wire logic txValid,
   input wire logic [7:0] txData,
   output logic txReady,
   output logic [127:0] capHdr,
   output logic [15:0] capCnt,
   input wire logic sendGo,
   input wire logic [127:0] sendHdr,
   input wire logic [7:0] payLen,
   output logic rxValid,
   output logic [7:0] rxData
);
   logic [127:0] shiftHdr;
   logic [8:0] left;
   // Accept bytes, every other cycle while stalling
   always_ff @(posedge core_clk) begin
      if (rst) begin
         txReady <= 1'b0;
         capCnt <= 16'h0;
      end else begin
         txReady <= stall ? !txReady : 1'b1;
         if (txValid && txReady) begin
            capHdr <= {capHdr[119:0], txData}; // High byte first
            capCnt <= capCnt + 16'h1;
         end
      end
   end
   // Header bytes in order, then zero payload bytes
   always_ff @(posedge core_clk) begin
      if (rst) begin
         left <= 9'h0;
         rxValid <= 1'b0;
         rxData <= 8'h0;
      end else if (sendGo) begin
         left <= 9'd15 + {1'b0, payLen};
         shiftHdr <= {sendHdr[119:0], 8'h00};
         rxValid <= 1'b1;
         rxData <= sendHdr[127:120];
      end else if (left != 9'h0) begin
         left <= left - 9'h1;
         shiftHdr <= {shiftHdr[119:0], 8'h00};
         rxData <= shiftHdr[127:120];
      end else begin
         rxValid <= 1'b0;
         rxData <= ~rxData;
      end
   end
endmodule : pthf_remote_station
`default_nettype wire

/* File: test_pthf_framer.sv */
// Purpose: Self-checking bench for the framer.
// Assumes: 200 MHz clock, station model on both streams.
// Notes: Table rows run tasks; rx and refusals by hand.
`timescale 1ns/1ps
`default_nettype none
module test_pthf_framer import pthf_pkg::*;;
   typedef struct packed {
      logic [7:0] op, er; logic [1:0] pr; logic msg, st; logic [7:0] aop, aer;
   } pthf_row_t;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, resp;
   logic [31:0] s_axi_rdata, rd;
   logic txValid, txLast, txReady, rxValid;
   logic [7:0] txData, rxData;
   logic stall = 1'b0, sendGo = 1'b0;
   logic [127:0] sendHdr = 128'h0, capHdr;
   logic [7:0] payLen = 8'h0;
   logic [15:0] capCnt;
   int err_count = 0, n_compared = 0;
   pthf_row_t rows [5] = '{
      '{OP_WRITE_REQ, 8'h00, 2'd1, 1'b1, 1'b0, OP_WRITE_ACK, 8'h00},
      '{OP_READ_REQ, 8'h00, 2'd1, 1'b0, 1'b1, OP_READ_ACK, 8'h03},
      '{OP_TRANSP, 8'h00, 2'd2, 1'b0, 1'b0, OP_WRITE_ACK, 8'h00},
      '{OP_WRITE_ACK, 8'h00, 2'd3, 1'b0, 1'b1, OP_READ_ACK, 8'h09},
      '{OP_READ_ACK, 8'h05, 2'd0, 1'b0, 1'b0, OP_WRITE_ACK, 8'h0a}};
   // Clock
   always #2.5 core_clk = ~core_clk;
   pthf_framer pthf_framer_i (.core_clk, .rst, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .txValid, .txData, .txLast, .txReady,
      .rxValid, .rxData);
   pthf_remote_station pthf_remote_station_i (.core_clk, .rst, .stall, .txValid, .txData,
      .txReady, .capHdr, .capCnt, .sendGo, .sendHdr, .payLen, .rxValid, .rxData);
   // Compare and count
   task automatic check(input logic [127:0] seen, input logic [127:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_count++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   function automatic logic [127:0] req_hdr(input logic [7:0] op, org, blk, input logic [31:0] sl);
      return {SYS_ID_0, SYS_ID_1, HDR_LEN_B, OP_IDENT, OP_LEN, op, ORG_BLK, ORG_BLK_LEN, org, blk,
         sl, UNUSED_BLK, UNUSED_LEN_REQ};
   endfunction : req_hdr
   function automatic logic [127:0] ack_hdr(input logic [7:0] op, er);
      return {SYS_ID_0, SYS_ID_1, HDR_LEN_B, OP_IDENT, OP_LEN, op, ACK_BLK, ACK_BLK_LEN, er,
         UNUSED_BLK, UNUSED_LEN_ACK, 40'h0};
   endfunction : ack_hdr
   // Register write, both channels offered together
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge core_clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      resp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask : axi_wr
   // Register read
   task automatic axi_rd(input logic [7:0] a);
      @(posedge core_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge core_clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      rd = s_axi_rdata;
      resp = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask : axi_rd
   // Start a task and compare the header it sends
   task automatic tx_go(input logic [31:0] ctl, input logic [127:0] exp, input logic [127:0] m);
      logic [15:0] c0;
      c0 = capCnt;
      axi_wr(REG_CTRL, ctl | 32'h1);
      while (capCnt != c0 + 16'd16) @(posedge core_clk);
      check(capHdr & m, exp & m);
   endtask : tx_go
   // Remote sends one frame
   task automatic rx_send(input logic [127:0] h, input logic [7:0] pl);
      @(posedge core_clk);
      sendHdr <= h;
      payLen <= pl;
      sendGo <= 1'b1;
      @(posedge core_clk);
      sendGo <= 1'b0;
      @(posedge core_clk);
      while (rxValid) @(posedge core_clk);
   endtask : rx_send
   task automatic give_verdict();
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : give_verdict
   // Watchdog
   initial begin
      #200000;
      err_count++;
      give_verdict();
   end
   // Main sequence
   initial begin
      pthf_row_t r;
      logic [31:0] ctl;
      logic ack, hs;
      logic [15:0] c0;
      repeat (12) @(posedge core_clk);
      rst <= 1'b0;
      repeat (2) @(posedge core_clk);
      axi_rd(REG_INDIC);
      check(rd, 32'h0);
      axi_rd(8'h40);
      check({resp, rd}, {RESP_DECERR, 32'h0});
      axi_wr(REG_STATUS, 32'h7);
      check(resp, RESP_DECERR);
      axi_wr(REG_TXORG, 32'h0a01);
      axi_wr(REG_TXADDR, 32'h1234_0020);
      $display("reset and map done");
      for (int i = 0; i < 5; i++) begin
         r = rows[i];
         stall <= r.st;
         ctl = {3'b000, 2'b11, r.msg, r.pr, r.er, r.op, 8'h00};
         ack = (r.op == OP_WRITE_ACK) || (r.op == OP_READ_ACK);
         hs = (r.pr == 2'd1 && r.msg) || r.pr[1];
         tx_go(ctl, ack ? ack_hdr(r.op, r.er) : req_hdr(r.op, 8'h01, 8'h0a, 32'h1234_0020),
            ack ? {{88{1'b1}}, 40'h0} : '1);
         axi_rd(REG_INDIC);
         check(rd[3:0], {2'b00, 1'b1, hs});
         rx_send(ack_hdr(r.aop, r.aer), 8'h0); // Next go only after this ack
         axi_rd(REG_INDIC);
         check({rd[11:8], rd[3:0]}, {r.aer[3:0], r.aer != 8'h0, r.aer == 8'h0, 1'b0, hs});
         $display("row %0d done", i);
      end
      stall <= 1'b0;
      axi_wr(REG_TXADDR, 32'h1234_ffff);
      c0 = capCnt;
      axi_wr(REG_CTRL, 32'h1800_0301);
      repeat (20) @(posedge core_clk);
      axi_rd(REG_INDIC);
      check({capCnt, rd[1]}, {c0, 1'b0});
      $display("forbidden length done");
      axi_wr(REG_TXADDR, 32'h1234_0020);
      axi_wr(REG_CTRL, 32'h1000_0301);
      axi_rd(REG_INDIC);
      check({rd[11:8], rd[3:0]}, {ERR_NO_TASK, 4'h8});
      axi_wr(REG_CTRL, 32'h0800_0301);
      axi_rd(REG_INDIC);
      check({rd[11:8], rd[3:0]}, {ERR_NO_CONN, 4'h8});
      $display("error codes done");
      axi_wr(REG_CTRL, 32'h1a00_0000); // Receive handshake possible
      axi_wr(8'h14, 32'hffff);
      rx_send(req_hdr(OP_TRANSP, 8'h01, 8'h07, 32'h0000_0005), 8'd5);
      axi_rd(REG_XFER);
      check(rd[15:0], 16'h5);
      axi_rd(REG_RXORG);
      check(rd[15:0], {8'h01, OP_TRANSP});
      rx_send(req_hdr(OP_WRITE_REQ, 8'h02, 8'h09, 32'h0010_0003), 8'd3);
      axi_rd(REG_RXORG);
      check(rd[23:0], {8'h09, 8'h02, OP_WRITE_REQ});
      axi_wr(REG_CTRL, 32'h1a00_0060);
      rx_send(req_hdr(OP_TRANSP, 8'h01, 8'h00, 32'h0000_0002), 8'd4);
      axi_rd(REG_XFER);
      check(rd[15:0], 16'h2);
      rx_send(req_hdr(OP_READ_REQ, 8'h03, 8'h04, 32'h0000_0001), 8'd0);
      axi_rd(REG_RXORG);
      check(rd[23:0], {8'h04, 8'h03, OP_READ_REQ});
      $display("receive done");
      rx_send(req_hdr(OP_READ_REQ, 8'h03, 8'h04, 32'h1) ^ {8'h00, 8'h03, 112'h0}, 8'd0);
      axi_rd(REG_STATUS);
      check(rd[2], 1'b1);
      $display("malformed done");
      give_verdict();
   end
endmodule : test_pthf_framer
`default_nettype wire
